// ---- include/bgc_pkg.sv ----
// Constants shared by the bridge gate control block.
package bgc_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int unsigned BGC_NHB   = 3;
   localparam int unsigned BGC_NDRV  = 6;
   localparam int unsigned BGC_NEVT  = 10;
   localparam int unsigned BGC_AW    = 8;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] BGC_OFS_ENABLE = 8'h00;
   localparam logic [7:0] BGC_OFS_CTRL   = 8'h04;
   localparam logic [7:0] BGC_OFS_MAP    = 8'h08;
   localparam logic [7:0] BGC_OFS_STAT   = 8'h0c;
   localparam logic [7:0] BGC_OFS_IEN    = 8'h10;
   localparam logic [7:0] BGC_OFS_STATE  = 8'h14;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int unsigned BGC_EN_DRV_POS  = 0;
   localparam int unsigned BGC_EN_CSA_POS  = 1;
   localparam int unsigned BGC_EN_CSC_POS  = 2;
   localparam int unsigned BGC_HB_EN_POS   = 0;
   localparam int unsigned BGC_HS_ON_POS   = 4;
   localparam int unsigned BGC_LS_ON_POS   = 8;
   localparam int unsigned BGC_HS_PWM_POS  = 12;
   localparam int unsigned BGC_LS_PWM_POS  = 16;
   localparam int unsigned BGC_MAP_STRIDE  = 4;
   localparam int unsigned BGC_ST_MODE_POS = 0;
   localparam int unsigned BGC_ST_SAFE_POS = 2;
   localparam int unsigned BGC_ST_STG_POS  = 3;
   localparam int unsigned BGC_ST_GATE_POS = 8;

   // ****************************************************************
   // Event numbers
   // ****************************************************************
   localparam int unsigned BGC_EVT_OVERCURRENT = 0;
   localparam int unsigned BGC_EVT_DS_MON      = 1;
   localparam int unsigned BGC_EVT_SEQ_ISSUE   = 2;
   localparam int unsigned BGC_EVT_CROSS_COND  = 3;
   localparam int unsigned BGC_EVT_ACT_DRIVER  = 4;
   localparam int unsigned BGC_EVT_PUMP_LOW    = 5;
   localparam int unsigned BGC_EVT_SUPPLY_OV   = 6;
   localparam int unsigned BGC_EVT_PUMP_OT     = 7;
   localparam int unsigned BGC_EVT_SUPPLY_LOW  = 8;
   localparam int unsigned BGC_EVT_PUMP_HIGH   = 9;

   // ****************************************************************
   // Reset values and counts
   // ****************************************************************
   localparam logic [2:0]  BGC_ENABLE_RST = 3'h0;
   localparam logic [31:0] BGC_CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] BGC_MAP_RST    = 32'h0065_4210;
   localparam logic [9:0]  BGC_IEN_RST    = 10'h000;
   localparam logic [9:0]  BGC_ACT_MASK   = 10'h010;
   localparam logic [9:0]  BGC_FAIL_MASK  = 10'h3ef;
   localparam logic [1:0]  BGC_FILT_TICKS = 2'h3;
   localparam logic [2:0]  BGC_SEL_OFF    = 3'h7;
   localparam logic [1:0]  BGC_SEL_C      = 2'h3;

   // ****************************************************************
   // Driver modes
   // ****************************************************************
   typedef enum logic [1:0] {
      BGC_MODE_OFF      = 2'b00,
      BGC_MODE_ACTIVE   = 2'b01,
      BGC_MODE_FAILSAFE = 2'b11,
      BGC_MODE_PWRDOWN  = 2'b10
   } bgc_mode_t;

endpackage

// ---- verilog/bgc_top.sv ----
// Bridge gate control: registers, driver control, event filtering and interrupt lines.
`timescale 1ns/1ps
`default_nettype none

module bgc_top (
   // Clock and reset.
   input  wire logic                         clk_i,
   input  wire logic                         rst_n_i,
   input  wire logic                         filter_blank_clock_i,
   // Register port.
   input  wire logic [bgc_pkg::BGC_AW-1:0]   reg_addr_i,
   input  wire logic [31:0]                  reg_wdata_i,
   input  wire logic                         reg_wr_i,
   input  wire logic                         reg_rd_i,
   output logic      [31:0]                  reg_rdata_o,
   // PWM inputs.
   input  wire logic [2:0]                   pwm_group_a_i,
   input  wire logic [2:0]                   pwm_group_b_i,
   input  wire logic [5:0]                   pwm_group_c_i,
   // System and safety inputs.
   input  wire logic                         shutdown_request_i,
   input  wire logic                         safe_enable_i,
   input  wire logic                         safe_shutdown_i,
   input  wire logic                         safe_off_fast_discharge_i,
   input  wire logic                         stop_request_i,
   input  wire logic                         sleep_request_i,
   input  wire logic                         fail_safe_i,
   // Converter monitoring flags.
   input  wire logic                         pump_out_low_flag_i,
   input  wire logic                         pump_out_high_flag_i,
   input  wire logic                         supply_low_flag_i,
   input  wire logic                         supply_high_flag_i,
   input  wire logic                         supply_pump_stage_flag_i,
   input  wire logic                         pump_overtemp_flag_i,
   // Protection detector inputs.
   input  wire logic                         overcurrent_det_i,
   input  wire logic                         ds_monitor_det_i,
   input  wire logic                         seq_issue_det_i,
   input  wire logic                         cross_cond_det_i,
   input  wire logic                         active_driver_det_i,
   // Gate driver controls.
   output logic      [bgc_pkg::BGC_NDRV-1:0] gate_charge_o,
   output logic      [bgc_pkg::BGC_NDRV-1:0] gate_current_en_o,
   output logic      [bgc_pkg::BGC_NDRV-1:0] gate_pulldown_o,
   output logic                              fast_discharge_o,
   output logic                              current_sense_amp_en_o,
   output logic                              current_sense_comp_en_o,
   // Events and requests.
   output logic      [bgc_pkg::BGC_NEVT-1:0] event_pulse_o,
   output logic                              supply_overvolt_wake_o,
   output logic                              active_driver_irq_o,
   output logic                              failure_irq_o
);
   import bgc_pkg::*;

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   localparam int unsigned SYNC_W = 31;

   logic [SYNC_W-1:0] async_in;
   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] sync_q;
   logic              fclk_prev_q;

   assign async_in = {pwm_group_a_i, pwm_group_b_i, pwm_group_c_i,
                      shutdown_request_i, safe_enable_i, safe_shutdown_i,
                      safe_off_fast_discharge_i, stop_request_i, sleep_request_i,
                      fail_safe_i, pump_out_low_flag_i, pump_out_high_flag_i,
                      supply_low_flag_i, supply_high_flag_i, supply_pump_stage_flag_i,
                      pump_overtemp_flag_i, filter_blank_clock_i, overcurrent_det_i,
                      ds_monitor_det_i, seq_issue_det_i, cross_cond_det_i,
                      active_driver_det_i};

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_q      <= '0;
         sync_q      <= '0;
         fclk_prev_q <= 1'b0;
      end else begin
         meta_q      <= async_in;
         sync_q      <= meta_q;
         fclk_prev_q <= sync_q[5];
      end
   end

   logic [2:0] pwm_a_s;
   logic [2:0] pwm_b_s;
   logic [5:0] pwm_c_s;
   logic       sd_s;
   logic       safe_en_s;
   logic       safe_sd_s;
   logic       fast_dis_s;
   logic       stop_s;
   logic       sleep_s;
   logic       fail_s;
   logic       stage_s;
   logic       fclk_tick;
   logic [9:0] evt_raw;

   assign pwm_a_s    = sync_q[30:28];
   assign pwm_b_s    = sync_q[27:25];
   assign pwm_c_s    = sync_q[24:19];
   assign sd_s       = sync_q[18];
   assign safe_en_s  = sync_q[17];
   assign safe_sd_s  = sync_q[16];
   assign fast_dis_s = sync_q[15];
   assign stop_s     = sync_q[14];
   assign sleep_s    = sync_q[13];
   assign fail_s     = sync_q[12];
   assign stage_s    = sync_q[7];
   assign fclk_tick  = sync_q[5] & ~fclk_prev_q;
   // Event sources in event-number order.
   assign evt_raw = {sync_q[10], sync_q[9], sync_q[6], sync_q[8], sync_q[11],
                     sync_q[0], sync_q[1], sync_q[2], sync_q[3], sync_q[4]};

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   logic       pwr_down;
   logic       cfg_clear;
   logic       wr_en;
   logic       wr_ctrl;
   logic       wr_map;
   logic [2:0] enable_q;
   logic [2:0] hb_en_q;
   logic [5:0] on_q;
   logic [5:0] pwm_q;
   logic [2:0] sel_q [BGC_NDRV];
   logic [9:0] ien_q;

   assign pwr_down  = stop_s | sleep_s;
   assign cfg_clear = !rst_n_i || pwr_down;
   assign wr_en     = reg_wr_i && !pwr_down;
   assign wr_ctrl   = wr_en && (reg_addr_i == BGC_OFS_CTRL);
   assign wr_map    = wr_en && (reg_addr_i == BGC_OFS_MAP) && (pwm_q == 6'h00);

   always_ff @(posedge clk_i) begin
      if (cfg_clear) begin
         enable_q <= BGC_ENABLE_RST;
         ien_q    <= BGC_IEN_RST;
      end else if (wr_en && reg_addr_i == BGC_OFS_ENABLE) begin
         enable_q <= reg_wdata_i[2:0];
      end else if (wr_en && reg_addr_i == BGC_OFS_IEN) begin
         ien_q    <= reg_wdata_i[9:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (cfg_clear) begin
         hb_en_q <= BGC_CTRL_RST[BGC_HB_EN_POS +: 3];
         on_q    <= '0;
         pwm_q   <= '0;
      end else if (wr_ctrl) begin
         hb_en_q <= reg_wdata_i[BGC_HB_EN_POS +: 3];
         on_q    <= {reg_wdata_i[BGC_LS_ON_POS +: 3], reg_wdata_i[BGC_HS_ON_POS +: 3]};
         pwm_q   <= {reg_wdata_i[BGC_LS_PWM_POS +: 3], reg_wdata_i[BGC_HS_PWM_POS +: 3]};
      end
   end

   // ****************************************************************
   // Driver mode
   // ****************************************************************
   bgc_mode_t mode_q;
   bgc_mode_t mode_d;

   always_comb begin
      if (pwr_down) begin
         mode_d = BGC_MODE_PWRDOWN;
      end else if (fail_s) begin
         mode_d = BGC_MODE_FAILSAFE;
      end else if (enable_q[BGC_EN_DRV_POS] && !sd_s && !safe_sd_s) begin
         mode_d = BGC_MODE_ACTIVE;
      end else begin
         mode_d = BGC_MODE_OFF;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mode_q <= BGC_MODE_OFF;
      end else begin
         mode_q <= mode_d;
      end
   end

   logic drive_ok;
   logic pulldown_all;

   always_comb begin
      unique case (mode_q)
         BGC_MODE_OFF: begin
            drive_ok     = 1'b0;
            pulldown_all = 1'b1;
         end
         BGC_MODE_ACTIVE: begin
            drive_ok     = 1'b1;
            pulldown_all = 1'b0;
         end
         BGC_MODE_FAILSAFE: begin
            drive_ok     = 1'b0;
            pulldown_all = 1'b1;
         end
         BGC_MODE_PWRDOWN: begin
            drive_ok     = 1'b0;
            pulldown_all = 1'b1;
         end
      endcase
   end

   // ****************************************************************
   // Per-driver control and source selection
   // ****************************************************************
   logic [5:0] charge_d;
   logic [5:0] cur_en_d;
   logic [2:0] hb_ok;

   assign hb_ok = hb_en_q & {3{drive_ok && safe_en_s}};

   for (genvar k = 0; k < BGC_NDRV; k++) begin : g_drv
      localparam int unsigned HB = k % BGC_NHB;
      logic       src_sig;
      logic       pwm_eff;

      always_ff @(posedge clk_i) begin
         if (cfg_clear) begin
            sel_q[k] <= BGC_MAP_RST[k*BGC_MAP_STRIDE +: 3];
         end else if (wr_map) begin
            sel_q[k] <= reg_wdata_i[k*BGC_MAP_STRIDE +: 3];
         end
      end

      always_comb begin
         if (sel_q[k] == BGC_SEL_OFF) begin
            src_sig = 1'b0;
         end else if (sel_q[k][1:0] == BGC_SEL_C) begin
            src_sig = pwm_c_s[k];
         end else if (sel_q[k][2]) begin
            src_sig = pwm_b_s[sel_q[k][1:0]];
         end else begin
            src_sig = pwm_a_s[sel_q[k][1:0]];
         end
      end

      assign pwm_eff     = pwm_q[k] && !on_q[HB] && !on_q[HB+BGC_NHB];
      assign charge_d[k] = hb_ok[HB] && (on_q[k] || (pwm_eff && src_sig));
      assign cur_en_d[k] = hb_ok[HB];
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         gate_charge_o           <= '0;
         gate_current_en_o       <= '0;
         gate_pulldown_o         <= '1;
         fast_discharge_o        <= 1'b0;
         current_sense_amp_en_o  <= 1'b0;
         current_sense_comp_en_o <= 1'b0;
      end else begin
         gate_charge_o           <= charge_d;
         gate_current_en_o       <= cur_en_d;
         gate_pulldown_o         <= ~cur_en_d | {BGC_NDRV{pulldown_all}};
         fast_discharge_o        <= fast_dis_s && (safe_sd_s || !safe_en_s);
         current_sense_amp_en_o  <= enable_q[BGC_EN_CSA_POS] && !pwr_down;
         current_sense_comp_en_o <= enable_q[BGC_EN_CSC_POS] && !pwr_down;
      end
   end

   // ****************************************************************
   // Event filtering and status
   // ****************************************************************
   logic [9:0] evt_qual;
   logic [9:0] evt_prev_q;
   logic [9:0] evt_set;
   logic [9:0] stat_q;

   for (genvar e = 0; e < BGC_NEVT; e++) begin : g_evt
      logic [1:0] cnt_q;

      always_ff @(posedge clk_i) begin
         if (!rst_n_i || !evt_raw[e]) begin
            cnt_q <= '0;
         end else if (fclk_tick && cnt_q != BGC_FILT_TICKS) begin
            cnt_q <= cnt_q + 2'h1;
         end
      end

      assign evt_qual[e] = (cnt_q == BGC_FILT_TICKS);
   end

   assign evt_set = evt_qual & ~evt_prev_q;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         evt_prev_q    <= '0;
         event_pulse_o <= '0;
      end else begin
         evt_prev_q    <= evt_qual;
         event_pulse_o <= evt_set;
      end
   end

   always_ff @(posedge clk_i) begin
      if (cfg_clear) begin
         stat_q <= '0;
      end else if (wr_en && reg_addr_i == BGC_OFS_STAT) begin
         stat_q <= (stat_q & ~reg_wdata_i[9:0]) | evt_set;
      end else begin
         stat_q <= stat_q | evt_set;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         active_driver_irq_o    <= 1'b0;
         failure_irq_o          <= 1'b0;
         supply_overvolt_wake_o <= 1'b0;
      end else begin
         active_driver_irq_o    <= |(stat_q & ien_q & BGC_ACT_MASK);
         failure_irq_o          <= |(stat_q & ien_q & BGC_FAIL_MASK);
         supply_overvolt_wake_o <= evt_qual[BGC_EVT_SUPPLY_OV] && mode_q != BGC_MODE_ACTIVE;
      end
   end

   // ****************************************************************
   // Register read port
   // ****************************************************************
   logic [31:0] rd_d;
   logic [31:0] map_rd;

   always_comb begin
      map_rd = '0;
      for (int k = 0; k < BGC_NDRV; k++) begin
         map_rd[k*BGC_MAP_STRIDE +: 3] = sel_q[k];
      end
   end

   always_comb begin
      rd_d = '0;
      unique case (reg_addr_i)
         BGC_OFS_ENABLE: rd_d[2:0] = enable_q;
         BGC_OFS_CTRL: begin
            rd_d[BGC_HB_EN_POS +: 3]  = hb_en_q;
            rd_d[BGC_HS_ON_POS +: 3]  = on_q[2:0];
            rd_d[BGC_LS_ON_POS +: 3]  = on_q[5:3];
            rd_d[BGC_HS_PWM_POS +: 3] = pwm_q[2:0];
            rd_d[BGC_LS_PWM_POS +: 3] = pwm_q[5:3];
         end
         BGC_OFS_MAP:  rd_d = map_rd;
         BGC_OFS_STAT: rd_d[9:0] = stat_q;
         BGC_OFS_IEN:  rd_d[9:0] = ien_q;
         BGC_OFS_STATE: begin
            rd_d[BGC_ST_MODE_POS +: 2] = mode_q;
            rd_d[BGC_ST_SAFE_POS]      = safe_en_s;
            rd_d[BGC_ST_STG_POS]       = stage_s;
            rd_d[BGC_ST_GATE_POS +: 6] = gate_charge_o;
         end
         default: rd_d = '0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rd_d;
      end else begin
         reg_rdata_o <= '0;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_map_write_lock: assert property ((wr_en && reg_addr_i == BGC_OFS_MAP && pwm_q != 6'h00
      && !cfg_clear) |=> map_rd == $past(map_rd)) else $error("map changed under PWM");
   a_safe_gate_off: assert property (!safe_en_s |=> gate_current_en_o == 6'h00)
      else $error("bridge enabled without safe enable");
   a_fail_safe_off: assert property (mode_q == BGC_MODE_FAILSAFE |=> gate_current_en_o == 6'h00
      && gate_pulldown_o == 6'h3f) else $error("fail-safe outputs wrong");
   a_static_on_hs: assert property ((hb_ok[0] && on_q[0] && !on_q[3]) |=> gate_charge_o[0])
      else $error("static on not driven");
   a_pwm_blocked: assert property ((hb_ok[0] && on_q[3] && !on_q[0] && pwm_q[0])
      |=> !gate_charge_o[0]) else $error("PWM active beside static on");
   a_fail_irq_on: assert property (|(stat_q & ien_q & BGC_FAIL_MASK) |=> failure_irq_o)
      else $error("failure line not raised");
   a_act_irq_on: assert property (evt_set[BGC_EVT_ACT_DRIVER] && ien_q[BGC_EVT_ACT_DRIVER]
      && !cfg_clear |=> ##1 active_driver_irq_o) else $error("active driver line late");
   a_ov_wake: assert property ((evt_qual[BGC_EVT_SUPPLY_OV] && mode_q == BGC_MODE_OFF)
      |=> supply_overvolt_wake_o) else $error("overvoltage wake missing");
   a_pwr_down_clr: assert property (pwr_down |=> hb_en_q == 3'h0 && pwm_q == 6'h00
      && map_rd == BGC_MAP_RST) else $error("power-down kept config");
   a_event_fwd: assert property (evt_set != 10'h000 |=> event_pulse_o == $past(evt_set))
      else $error("event not forwarded");

endmodule

`default_nettype wire

// ---- bench/bgc_far_model.sv ----
// Far-side model of the PWM timer unit and the power management safety enable.
`timescale 1ns/1ps
`default_nettype none

module bgc_far_model (
   // Clock.
   input  wire logic       clk_i,
   // Requested levels from the bench.
   input  wire logic [5:0] pwm_set_i,
   input  wire logic       sen_set_i,
   // Levels toward the block.
   output logic      [2:0] pwm_group_a_o,
   output logic      [2:0] pwm_group_b_o,
   output logic            safe_enable_o
);
   // Levels change only just after a clock edge and then hold.
   always_ff @(posedge clk_i) begin
      pwm_group_a_o <= pwm_set_i[2:0];
      pwm_group_b_o <= pwm_set_i[5:3];
      safe_enable_o <= sen_set_i;
   end
endmodule

`default_nettype wire

// ---- bench/tb_bgc_top.sv ----
// Self-checking testbench of the bridge gate control block.
`timescale 1ns/1ps
`default_nettype none

module tb_bgc_top;
   import bgc_pkg::*;
   logic clk = 0, rst_n = 0, fclk = 0, wr = 0, rd = 0, sen_set = 0;
   logic [7:0] addr = 0;
   logic [31:0] wd = 0, rdata, rv;
   logic [5:0] pw = 0, pc = 0, sys = 0, mon = 0, chg, cen, pd;
   logic [4:0] det = 0;
   logic [2:0] pa, pb;
   logic [9:0] evp;
   logic sen, fd, amp, cmp, wake, irq_a, irq_f;
   int mismatches = 0, cmp_count = 0, en_m = 0, ctrl_m = 0, map_m = BGC_MAP_RST;

   initial forever #12.5 clk = ~clk;
   initial forever #50 fclk = ~fclk;
   initial begin
      #(10000 * 25);
      mismatches++;
      summarize();
   end

   bgc_far_model i_bgc_far_model (.clk_i(clk), .pwm_set_i(pw), .sen_set_i(sen_set),
      .pwm_group_a_o(pa), .pwm_group_b_o(pb), .safe_enable_o(sen));

   bgc_top i_bgc_top (.clk_i(clk), .rst_n_i(rst_n), .filter_blank_clock_i(fclk),
      .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .pwm_group_a_i(pa), .pwm_group_b_i(pb), .pwm_group_c_i(pc),
      .shutdown_request_i(sys[0]), .safe_enable_i(sen), .safe_shutdown_i(sys[1]),
      .safe_off_fast_discharge_i(sys[2]), .stop_request_i(sys[3]), .sleep_request_i(sys[4]),
      .fail_safe_i(sys[5]), .pump_out_low_flag_i(mon[0]), .pump_out_high_flag_i(mon[1]),
      .supply_low_flag_i(mon[2]), .supply_high_flag_i(mon[3]),
      .supply_pump_stage_flag_i(mon[4]), .pump_overtemp_flag_i(mon[5]),
      .overcurrent_det_i(det[0]), .ds_monitor_det_i(det[1]), .seq_issue_det_i(det[2]),
      .cross_cond_det_i(det[3]), .active_driver_det_i(det[4]),
      .gate_charge_o(chg), .gate_current_en_o(cen), .gate_pulldown_o(pd),
      .fast_discharge_o(fd), .current_sense_amp_en_o(amp), .current_sense_comp_en_o(cmp),
      .event_pulse_o(evp), .supply_overvolt_wake_o(wake), .active_driver_irq_o(irq_a),
      .failure_irq_o(irq_f));

   task automatic summarize();
      if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         mismatches++;
      end
   endtask

   // Register write; the model keeps ENABLE, CTRL and MAP, with the MAP lock.
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a; wd <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      if (a == BGC_OFS_ENABLE) en_m = d;
      if (a == BGC_OFS_CTRL) ctrl_m = d;
      if (a == BGC_OFS_MAP && ctrl_m[18:16] == 0 && ctrl_m[14:12] == 0) map_m = d;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      chk(rdata, exp);
   endtask

   function automatic logic [11:0] exp_gate();
      logic [11:0] r;
      logic src;
      int h, c;
      r = 0;
      for (int k = 0; k < 6; k++) begin
         h = k % 3;
         c = (map_m >> (4 * k)) & 7;
         src = c < 3 ? pw[c] : c == 3 ? pc[k] : c == 7 ? 1'b0 : pw[c - 1];
         r[k + 6] = ctrl_m[h] && sen_set && en_m[0] && sys[1:0] == 0 && !sys[5];
         r[k] = ctrl_m[k < 3 ? 4 + k : 8 + h] || (ctrl_m[k < 3 ? 12 + k : 16 + h] && src
                && !ctrl_m[4 + h] && !ctrl_m[8 + h]);
      end
      return r;
   endfunction

   // Random PWM levels, then gate outputs against the model.
   task automatic run(input int n);
      logic [11:0] e;
      repeat (n) begin
         @(posedge clk);
         pw <= 6'($urandom);
         repeat (8) @(posedge clk);
         e = exp_gate();
         chk(32'({cen, chg}), 32'({e[11:6], e[5:0] & e[11:6]}));
      end
   endtask

   initial begin
      void'($urandom(51));
      pc <= 6'($urandom);
      repeat (6) @(posedge clk);
      chk(32'(pd), 32'h3f);
      chk(32'({chg, cen, fd, amp, cmp, evp, wake, irq_a, irq_f}), 32'h0);
      rst_n <= 1'b1;
      rd_chk(BGC_OFS_MAP, BGC_MAP_RST);
      rd_chk(BGC_OFS_ENABLE, 32'h0);
      wr_reg(BGC_OFS_ENABLE, 32'h7);
      sen_set <= 1'b1;
      wr_reg(BGC_OFS_CTRL, 32'h77007);
      run(8);
      chk(32'({amp, cmp}), 32'h3);
      wr_reg(BGC_OFS_CTRL, 32'h77107);
      run(8);
      wr_reg(BGC_OFS_CTRL, 32'h77017);
      run(4);
      wr_reg(BGC_OFS_MAP, 32'h00376012);
      rd_chk(BGC_OFS_MAP, BGC_MAP_RST);
      wr_reg(BGC_OFS_CTRL, 32'h7);
      wr_reg(BGC_OFS_MAP, 32'h00376012);
      rd_chk(BGC_OFS_MAP, 32'h00376012);
      wr_reg(BGC_OFS_CTRL, 32'h77007);
      run(8);
      sen_set <= 1'b0;
      run(2);
      sen_set <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         sys <= 6'(1 << i) | 6'h04;
         run(2);
         chk(32'(fd), 32'(i));
      end
      sys <= 6'h20;
      run(1);
      chk(32'(pd), 32'h3f);
      rd_chk(BGC_OFS_CTRL, 32'h77007);
      for (int i = 3; i < 5; i++) begin
         sys <= 6'(1 << i);
         repeat (6) @(posedge clk);
         rd_chk(BGC_OFS_STATE, 32'h6);
         sys <= 0;
         repeat (6) @(posedge clk);
         en_m = 0;
         ctrl_m = 0;
         map_m = BGC_MAP_RST;
         rd_chk(BGC_OFS_MAP, BGC_MAP_RST);
         rd_chk(BGC_OFS_ENABLE, 32'h0);
         rd_chk(BGC_OFS_CTRL, 32'h0);
      end
      rd_chk(BGC_OFS_STATE, 32'h4);
      wr_reg(BGC_OFS_IEN, 32'h010);
      det <= 5'h1f;
      mon <= 6'h3f;
      for (int n = 0; n < 40 && evp == 0; n++) @(posedge clk);
      chk(32'(evp), 32'h3ff);
      @(posedge clk);
      chk(32'(evp), 32'h0);
      repeat (30) @(posedge clk);
      rd_chk(BGC_OFS_STAT, 32'h3ff);
      rd_chk(BGC_OFS_STATE, 32'hc);
      chk(32'({irq_a, irq_f, wake}), 32'h5);
      wr_reg(BGC_OFS_IEN, 32'h3ff);
      repeat (3) @(posedge clk);
      chk(32'({irq_a, irq_f}), 32'h3);
      det <= 0;
      mon <= 0;
      repeat (30) @(posedge clk);
      wr_reg(BGC_OFS_STAT, 32'h3ff);
      repeat (3) @(posedge clk);
      chk(32'({irq_a, irq_f}), 32'h0);
      summarize();
   end
endmodule

`default_nettype wire
